// ==== src/pces_pkg.sv ====
// constants for the second performance counter event selection
package pces_pkg;
	localparam int unsigned PCES_CNT_W     = 32;
	localparam int unsigned PCES_SEL_W     = 6;
	localparam int unsigned PCES_SEL3_W    = 5;
	// select field sits at big-endian bits 26..31, little-endian 5..0
	localparam int unsigned PCES_SEL2_LSB  = 0;
	// third counter select at big-endian bits 0..4, little-endian 31..27
	localparam int unsigned PCES_SEL3_LSB  = 27;
	// time-base lower bits 47,51,55,63 in little-endian lower-word terms
	localparam int unsigned PCES_TB_BIT0   = 16;
	localparam int unsigned PCES_TB_BIT1   = 12;
	localparam int unsigned PCES_TB_BIT2   = 8;
	localparam int unsigned PCES_TB_BIT3   = 0;
	localparam logic [31:0] PCES_CNT_RST   = 32'h0000_0000;
	localparam logic [5:0]  PCES_SEL_RST   = 6'h00;
	localparam logic [4:0]  PCES_SEL3_RST  = 5'h00;
	localparam logic [2:0]  PCES_MAX_COUNT = 3'h4;
	localparam logic [2:0]  PCES_MAX_STQ   = 3'h6;
	localparam logic [1:0]  PCES_BR_NONE   = 2'h0;
	localparam logic [1:0]  PCES_BR_BAD    = 2'h1;
	localparam logic [1:0]  PCES_BR_ONE    = 2'h2;
	localparam logic [1:0]  PCES_BR_TWO    = 2'h3;
	localparam logic [5:0] EV_NONE        = 6'h00;
	localparam logic [5:0] EV_CYCLES      = 6'h01;
	localparam logic [5:0] EV_COMPLETED   = 6'h02;
	localparam logic [5:0] EV_TB_TOGGLE   = 6'h03;
	localparam logic [5:0] EV_DISPATCHED  = 6'h04;
	localparam logic [5:0] EV_LOAD_MISS   = 6'h05;
	localparam logic [5:0] EV_DC_MISS     = 6'h06;
	localparam logic [5:0] EV_ITLB_MISS   = 6'h07;
	localparam logic [5:0] EV_BRANCHES    = 6'h08;
	localparam logic [5:0] EV_RESV_OK     = 6'h09;
	localparam logic [5:0] EV_SPR_READ    = 6'h0a;
	localparam logic [5:0] EV_ICBI        = 6'h0b;
	localparam logic [5:0] EV_FLUSH       = 6'h0c;
	localparam logic [5:0] EV_BR_RES      = 6'h0d;
	localparam logic [5:0] EV_SIA_RES     = 6'h0e;
	localparam logic [5:0] EV_MCI_RES     = 6'h0f;
	localparam logic [5:0] EV_BR_DISP     = 6'h10;
	localparam logic [5:0] EV_SIA_DISP    = 6'h11;
	localparam logic [5:0] EV_LOADS       = 6'h12;
	localparam logic [5:0] EV_MCI_DISP    = 6'h13;
	localparam logic [5:0] EV_SNOOP_HIT   = 6'h14;
	localparam logic [5:0] EV_EE_CLEAR    = 6'h15;
	localparam logic [5:0] EV_MCI_IDLE    = 6'h16;
	localparam logic [5:0] EV_SIB_IDLE    = 6'h17;
	localparam logic [5:0] EV_FP_IDLE     = 6'h18;
	localparam logic [5:0] EV_L2_INTERV   = 6'h19;
	localparam logic [5:0] EV_DISP4       = 6'h1a;
	localparam logic [5:0] EV_DISP3       = 6'h1b;
	localparam logic [5:0] EV_DISP2       = 6'h1c;
	localparam logic [5:0] EV_DISP1       = 6'h1d;
	localparam logic [5:0] EV_UNAL_STORE  = 6'h1e;
	localparam logic [5:0] EV_STQ_LEVEL   = 6'h1f;
endpackage

// ==== src/pces_tb_edge.sv ====
// time-base bit transition detector for the counter event select
`timescale 1ns/1ns
module pces_tb_edge
	import pces_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] timebase_lower,
	input  wire logic [1:0]  timebase_bit_selector,
	output logic             toggle
);
	logic tap;
	logic prev;
	logic primed;
	logic next_prev;
	logic next_primed;
	logic next_toggle;
	logic [1:0] sel_q;

	always_comb begin
		unique case (timebase_bit_selector)
			2'h0:    tap = timebase_lower[PCES_TB_BIT0];
			2'h1:    tap = timebase_lower[PCES_TB_BIT1];
			2'h2:    tap = timebase_lower[PCES_TB_BIT2];
			2'h3:    tap = timebase_lower[PCES_TB_BIT3];
		endcase
	end

	// a selector change re-primes, so switching taps is not a transition
	always_comb begin
		next_prev   = tap;
		next_primed = (sel_q == timebase_bit_selector);
		next_toggle = primed && (sel_q == timebase_bit_selector)
			&& (tap != prev);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev   <= 1'b0;
			primed <= 1'b0;
			toggle <= 1'b0;
			sel_q  <= 2'h0;
		end else begin
			prev   <= next_prev;
			primed <= next_primed;
			toggle <= next_toggle;
			sel_q  <= timebase_bit_selector;
		end
	end
endmodule

// ==== src/pces_counter.sv ====
// second performance counter with its event selection and counting
// Summary of operation
// - event select for counter 2 is control-0 bits 26..31
// - select zero: counter holds its value
// - code 01: add one every clock
// - code 02: add instructions completed per cycle, zero to four
// - code 03: count transitions of time-base bit 47, 51, 55 or 63
// - code 04: add instructions dispatched per cycle, zero to four
// - codes 05-07: load-miss cycles, in-order dcache misses, itlb misses
// - code 08: add completed branches, 00 none 10 one 11 two
// - codes 09-0b: reservation success, spr reads, icbi instructions
// - code 0c: count pipeline flushing instructions
// - codes 0d-0f: results from branch, simple-a, multicycle units
// - codes 10,11,13: dispatches to branch, simple-a, multicycle units
// - code 12: loads completed, cache ops and barriers included
// - code 14 snoop hits; code 15 cycles with interrupts disabled
// - codes 16-18: idle cycles of multicycle, simple-b, float units
// - code 19: intervention cycles regardless of transfer acknowledge
// - codes 1a-1d: cycles with four, three, two, one dispatched
// - code 1e: count unaligned stores
// - code 1f: add store queue occupancy, at most six
// - counter 3 select is control-1 bits 0..4
// - counting runs from control-0 write until a monitor interrupt with freeze set
// - freeze bit set: monitor interrupt stops counting
`timescale 1ns/1ns
module pces_counter
	import pces_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic [31:0]           monitor_control_0,
	input  wire logic                  monitor_control_0_write,
	input  wire logic [31:0]           monitor_control_1,
	input  wire logic                  monitor_control_1_write,
	input  wire logic                  counter_freeze_on_interrupt,
	input  wire logic                  monitor_interrupt,
	input  wire logic                  perf_counter_2_write,
	input  wire logic [PCES_CNT_W-1:0] perf_counter_2_wdata,
	input  wire logic [1:0]            timebase_bit_selector,
	input  wire logic [31:0]           timebase_lower,
	input  wire logic [2:0]            completed_count,
	input  wire logic [2:0]            dispatched_count,
	input  wire logic [1:0]            branches_completed,
	input  wire logic [2:0]            store_queue_count,
	input  wire logic                  load_miss_busy,
	input  wire logic                  dcache_miss_in_order,
	input  wire logic                  itlb_miss,
	input  wire logic                  reservation_success,
	input  wire logic                  spr_read_dispatched,
	input  wire logic                  icbi_seen,
	input  wire logic                  flush_instruction,
	input  wire logic                  branch_unit_result,
	input  wire logic                  simple_int_unit_a_result,
	input  wire logic                  multicycle_int_unit_result,
	input  wire logic                  branch_unit_dispatch,
	input  wire logic                  simple_int_unit_a_dispatch,
	input  wire logic                  load_completed,
	input  wire logic                  multicycle_int_unit_dispatch,
	input  wire logic                  snoop_hit,
	input  wire logic                  external_interrupt_enable,
	input  wire logic                  multicycle_int_unit_idle,
	input  wire logic                  simple_int_unit_b_idle,
	input  wire logic                  float_unit_idle,
	input  wire logic                  secondary_cache_intervention,
	input  wire logic                  unaligned_store,
	output logic [PCES_CNT_W-1:0]      perf_counter_2,
	output logic [PCES_SEL_W-1:0]      counter_2_select,
	output logic [PCES_SEL3_W-1:0]     perf_counter_3_select,
	output logic                       counting_active
);
	logic                  tb_toggle;
	logic [2:0]            inc;
	logic [PCES_CNT_W-1:0] next_perf_counter_2;
	logic [PCES_SEL_W-1:0] next_counter_2_select;
	logic [PCES_SEL3_W-1:0] next_perf_counter_3_select;
	logic                  next_counting_active;

	pces_tb_edge u_tb_edge (
		.ref_clk               (ref_clk),
		.rst_n                 (rst_n),
		.timebase_lower        (timebase_lower),
		.timebase_bit_selector (timebase_bit_selector),
		.toggle                (tb_toggle)
	);

	// counts above the documented maxima are out of range and add nothing
	function automatic logic [2:0] clip(input logic [2:0] v,
		input logic [2:0] lim);
		clip = (v > lim) ? 3'h0 : v;
	endfunction

	// per-cycle increment for the selected event
	always_comb begin
		inc = 3'h0;
		unique case (counter_2_select)
			EV_NONE:       inc = 3'h0;
			EV_CYCLES:     inc = 3'h1;
			EV_COMPLETED:  inc = clip(completed_count,
				PCES_MAX_COUNT);
			EV_TB_TOGGLE:  inc = {2'h0, tb_toggle};
			EV_DISPATCHED: inc = clip(dispatched_count,
				PCES_MAX_COUNT);
			EV_LOAD_MISS:  inc = {2'h0, load_miss_busy};
			EV_DC_MISS:    inc = {2'h0, dcache_miss_in_order};
			EV_ITLB_MISS:  inc = {2'h0, itlb_miss};
			EV_BRANCHES: begin
				unique case (branches_completed)
					PCES_BR_ONE: inc = 3'h1;
					PCES_BR_TWO: inc = 3'h2;
					PCES_BR_BAD: inc = 3'h0;
					PCES_BR_NONE: inc = 3'h0;
				endcase
			end
			EV_RESV_OK:    inc = {2'h0, reservation_success};
			EV_SPR_READ:   inc = {2'h0, spr_read_dispatched};
			EV_ICBI:       inc = {2'h0, icbi_seen};
			EV_FLUSH:      inc = {2'h0, flush_instruction};
			EV_BR_RES:     inc = {2'h0, branch_unit_result};
			EV_SIA_RES:    inc = {2'h0, simple_int_unit_a_result};
			EV_MCI_RES:    inc = {2'h0, multicycle_int_unit_result};
			EV_BR_DISP:    inc = {2'h0, branch_unit_dispatch};
			EV_SIA_DISP:   inc = {2'h0, simple_int_unit_a_dispatch};
			EV_LOADS:      inc = {2'h0, load_completed};
			EV_MCI_DISP:   inc = {2'h0,
				multicycle_int_unit_dispatch};
			EV_SNOOP_HIT:  inc = {2'h0, snoop_hit};
			EV_EE_CLEAR:   inc = {2'h0, !external_interrupt_enable};
			EV_MCI_IDLE:   inc = {2'h0, multicycle_int_unit_idle};
			EV_SIB_IDLE:   inc = {2'h0, simple_int_unit_b_idle};
			EV_FP_IDLE:    inc = {2'h0, float_unit_idle};
			// transfer acknowledge deliberately plays no part here
			EV_L2_INTERV:  inc = {2'h0,
				secondary_cache_intervention};
			EV_DISP4:      inc = {2'h0, dispatched_count == 3'h4};
			EV_DISP3:      inc = {2'h0, dispatched_count == 3'h3};
			EV_DISP2:      inc = {2'h0, dispatched_count == 3'h2};
			EV_DISP1:      inc = {2'h0, dispatched_count == 3'h1};
			EV_UNAL_STORE: inc = {2'h0, unaligned_store};
			EV_STQ_LEVEL:  inc = clip(store_queue_count,
				PCES_MAX_STQ);
			default:       inc = 3'h0;
		endcase
	end

	// control capture and run state
	always_comb begin
		next_counter_2_select      = counter_2_select;
		next_perf_counter_3_select = perf_counter_3_select;
		next_counting_active       = counting_active;
		if (monitor_control_1_write) begin
			next_perf_counter_3_select =
				monitor_control_1[PCES_SEL3_LSB +: PCES_SEL3_W];
		end
		// a rewrite restarts counting even in the cycle of an interrupt
		if (monitor_control_0_write) begin
			next_counter_2_select =
				monitor_control_0[PCES_SEL2_LSB +: PCES_SEL_W];
			next_counting_active = 1'b1;
		end else if (monitor_interrupt && counter_freeze_on_interrupt) begin
			next_counting_active = 1'b0;
		end
	end

	// counter update; a software load takes priority over counting
	always_comb begin
		next_perf_counter_2 = perf_counter_2;
		if (perf_counter_2_write) begin
			next_perf_counter_2 = perf_counter_2_wdata;
		end else if (counting_active && !(monitor_interrupt
			&& counter_freeze_on_interrupt)) begin
			next_perf_counter_2 = perf_counter_2
				+ {{(PCES_CNT_W-3){1'b0}}, inc};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			perf_counter_2        <= PCES_CNT_RST;
			counter_2_select      <= PCES_SEL_RST;
			perf_counter_3_select <= PCES_SEL3_RST;
			counting_active       <= 1'b0;
		end else begin
			perf_counter_2        <= next_perf_counter_2;
			counter_2_select      <= next_counter_2_select;
			perf_counter_3_select <= next_perf_counter_3_select;
			counting_active       <= next_counting_active;
		end
	end
endmodule

// ==== sim/pces_counter_props.sv ====
// checker for the second counter's select and counting
`timescale 1ns/1ns
module pces_chk
	import pces_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic [31:0] monitor_control_0,
	input wire logic        monitor_control_0_write,
	input wire logic [31:0] monitor_control_1,
	input wire logic        monitor_control_1_write,
	input wire logic        counter_freeze_on_interrupt,
	input wire logic        monitor_interrupt,
	input wire logic        perf_counter_2_write,
	input wire logic [2:0]  completed_count,
	input wire logic [31:0] perf_counter_2,
	input wire logic [5:0]  counter_2_select,
	input wire logic [4:0]  perf_counter_3_select,
	input wire logic        counting_active
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	wire frz = monitor_interrupt && counter_freeze_on_interrupt;
	// write cycles excluded: select changes only after that edge
	wire go = counting_active && !perf_counter_2_write && !frz
		&& !monitor_control_0_write;
	sequence s_go(c); go && counter_2_select == c; endsequence
	property p_sel; monitor_control_0_write |=>
		counter_2_select == $past(monitor_control_0[5:0]); endproperty
	a_sel: assert property (p_sel) else $error("select");
	property p_sel3; monitor_control_1_write |=>
		perf_counter_3_select == $past(monitor_control_1[31:27]); endproperty
	a_sel3: assert property (p_sel3) else $error("select 3");
	property p_hold; s_go(EV_NONE) |=> $stable(perf_counter_2); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_cyc; s_go(EV_CYCLES) |=>
		perf_counter_2 == $past(perf_counter_2) + 32'h1; endproperty
	a_cyc: assert property (p_cyc) else $error("cycles");
	property p_comp; s_go(EV_COMPLETED) ##0 completed_count <= PCES_MAX_COUNT
		|=> perf_counter_2 == $past(perf_counter_2) + $past(completed_count);
	endproperty
	a_comp: assert property (p_comp) else $error("compl");
	property p_idle; !counting_active && !perf_counter_2_write |=>
		$stable(perf_counter_2); endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_act; monitor_control_0_write |=> counting_active; endproperty
	a_act: assert property (p_act) else $error("start");
	property p_frz; frz && !monitor_control_0_write && !perf_counter_2_write
		|=> !counting_active && $stable(perf_counter_2); endproperty
	a_frz: assert property (p_frz) else $error("freeze");
endmodule
bind pces_counter pces_chk pces_chk_inst (.*);

// ==== sim/pces_events.sv ====
// far-side model: pipeline and cache units raising event indications
`timescale 1ns/1ns
module pces_events
	import pces_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [5:0]  ev,
	input  wire logic [2:0]  n,
	input  wire logic [31:0] msk,
	output logic [31:0]      lvl,
	output logic [2:0]       comp,
	output logic [2:0]       disp,
	output logic [1:0]       br,
	output logic [2:0]       stq,
	output logic [31:0]      tbl
);
	// one source active at a time, so a wrong mux leg shows up
	assign lvl = 32'h0000_0001 << ev;
	assign comp = (ev == EV_COMPLETED) ? n : 3'h0;
	assign disp = (ev == EV_DISPATCHED || (ev >= EV_DISP4 && ev <= EV_DISP1))
		? n : 3'h0;
	assign br = (ev == EV_BRANCHES) ? n[1:0] : 2'h0;
	assign stq = (ev == EV_STQ_LEVEL) ? n : 3'h0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) tbl <= 32'h0000_0000;
		else tbl <= tbl ^ msk;
	end
endmodule

// ==== sim/pces_counter_tb_top.sv ====
// self-checking bench for the second counter's event selection
`timescale 1ns/1ns
module pces_counter_tb_top;
	import pces_pkg::*;
	logic        ref_clk = 1'b0, rst_n = 1'b0, w0 = 1'b0, w1 = 1'b0;
	logic        frz = 1'b0, irq = 1'b0, pw = 1'b0, act;
	logic [31:0] mc0 = 32'h0000_0000, mc1 = 32'h0000_0000, lvl, tbl, pc2;
	logic [31:0] wd = 32'h0000_0000, msk = 32'h0000_0000;
	logic [5:0]  ev = 6'h00, sel2, t;
	logic [2:0]  n = 3'h0, comp, disp, stq;
	logic [1:0]  tbs = 2'h0, br;
	logic [4:0]  sel3;
	int          error_cnt = 0, compares = 0;
	int          tbp [4] = '{PCES_TB_BIT0, PCES_TB_BIT1, PCES_TB_BIT2,
		PCES_TB_BIT3};
	// per code: {increase per cycle, source count}
	logic [5:0]  tab [32] = '{
		6'h00,6'h08,6'h24,6'h00,6'h1b,6'h08,6'h08,6'h08,
		6'h13,6'h08,6'h08,6'h08,6'h08,6'h08,6'h08,6'h08,
		6'h08,6'h08,6'h08,6'h08,6'h08,6'h08,6'h08,6'h08,
		6'h08,6'h08,6'h0c,6'h0b,6'h0a,6'h09,6'h08,6'h36};
	always #4 ref_clk = ~ref_clk;
	pces_events pces_events_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ev(ev),
		.n(n), .msk(msk), .lvl(lvl), .comp(comp), .disp(disp), .br(br),
		.stq(stq), .tbl(tbl));
	pces_counter pces_counter_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.monitor_control_0(mc0), .monitor_control_0_write(w0),
		.monitor_control_1(mc1), .monitor_control_1_write(w1),
		.counter_freeze_on_interrupt(frz), .monitor_interrupt(irq),
		.perf_counter_2_write(pw), .perf_counter_2_wdata(wd),
		.timebase_bit_selector(tbs), .timebase_lower(tbl),
		.completed_count(comp), .dispatched_count(disp),
		.branches_completed(br), .store_queue_count(stq),
		.load_miss_busy(lvl[5]), .dcache_miss_in_order(lvl[6]),
		.itlb_miss(lvl[7]), .reservation_success(lvl[9]),
		.spr_read_dispatched(lvl[10]), .icbi_seen(lvl[11]),
		.flush_instruction(lvl[12]), .branch_unit_result(lvl[13]),
		.simple_int_unit_a_result(lvl[14]),
		.multicycle_int_unit_result(lvl[15]),
		.branch_unit_dispatch(lvl[16]), .simple_int_unit_a_dispatch(lvl[17]),
		.load_completed(lvl[18]), .multicycle_int_unit_dispatch(lvl[19]),
		.snoop_hit(lvl[20]), .external_interrupt_enable(!lvl[21]),
		.multicycle_int_unit_idle(lvl[22]), .simple_int_unit_b_idle(lvl[23]),
		.float_unit_idle(lvl[24]), .secondary_cache_intervention(lvl[25]),
		.unaligned_store(lvl[30]), .perf_counter_2(pc2),
		.counter_2_select(sel2), .perf_counter_3_select(sel3),
		.counting_active(act));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) error_cnt++;
		if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
	endtask
	task automatic final_report();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// steady-state window, so pipeline latency drops out of the sum
	task automatic measure(input logic [31:0] per);
		logic [31:0] a;
		tick(4);
		a = pc2;
		tick(10);
		chk(pc2 - a, per * 32'h0000_000a);
	endtask
	task automatic run(input logic [5:0] c, input logic [2:0] v,
		input logic [31:0] per);
		@(posedge ref_clk);
		ev <= c;
		n <= v;
		mc0 <= {26'h3ff_ffff, c};
		w0 <= 1'b1;
		@(posedge ref_clk);
		w0 <= 1'b0;
		#1 chk(32'(sel2), 32'(c));
		measure(per);
	endtask
	task automatic pulse(input logic f);
		@(posedge ref_clk);
		frz <= f;
		irq <= 1'b1;
		@(posedge ref_clk);
		irq <= 1'b0;
		#1;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		measure(32'h0);
		for (int c = 0; c < 32; c++) begin
			t = tab[c];
			run(6'(c), t[2:0], 32'(t[5:3]));
		end
		run(EV_COMPLETED, 3'h5, 32'h0);
		run(EV_BRANCHES, 3'h1, 32'h0);
		run(EV_BRANCHES, 3'h2, 32'h1);
		run(EV_STQ_LEVEL, 3'h7, 32'h0);
		run(EV_DISP4, 3'h3, 32'h0);
		for (int s = 0; s < 4; s++) begin
			@(posedge ref_clk);
			tbs <= 2'(s);
			msk <= 32'h0000_0001 << tbp[s];
			run(EV_TB_TOGGLE, 3'h0, 32'h1);
			@(posedge ref_clk);
			msk <= ~(32'h0000_0001 << tbp[s]);
			measure(32'h0);
		end
		run(EV_CYCLES, 3'h0, 32'h1);
		pulse(1'b0);
		chk(32'(act), 32'h1);
		pulse(1'b1);
		chk(32'(act), 32'h0);
		measure(32'h0);
		run(EV_CYCLES, 3'h0, 32'h1);
		@(posedge ref_clk);
		pw <= 1'b1;
		wd <= 32'h1234_5678;
		@(posedge ref_clk);
		pw <= 1'b0;
		#1 chk(pc2, 32'h1234_5678);
		@(posedge ref_clk);
		mc1 <= 32'ha800_0000;
		w1 <= 1'b1;
		@(posedge ref_clk);
		w1 <= 1'b0;
		#1 chk(32'(sel3), 32'h0000_0015);
		final_report();
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		error_cnt++;
		final_report();
	end
endmodule
